// file: pkg/or_call_pkg.sv
// Constants, opcodes and state types for the OR-file and long-call unit
package or_call_pkg;

   // Datapath widths
   localparam int DATA_W = 8;
   localparam int PC_W   = 16;

   // Opcode of the OR-into-file instruction: bits 15:9 fixed
   localparam logic [6:0] IOR_OPC     = 7'h04;
   localparam int         IOR_OPC_LSB = 9;
   localparam int         IOR_DST_BIT = 8;

   // Opcode of the long call: bits 15:8 fixed
   localparam logic [7:0] CALL_OPC     = 8'hb7;
   localparam int         CALL_OPC_LSB = 8;

   // Destination select encodings
   localparam logic DST_WORK = 1'h0;
   localparam logic DST_FILE = 1'h1;

   // Values after reset
   localparam logic [7:0]  WORK_RST = 8'h00;
   localparam logic [15:0] PC_RST   = 16'h0000;
   localparam logic        ZF_RST   = 1'h0;

   // Return address offset and cycle counts
   localparam logic [15:0] PC_STEP     = 16'h0001;
   localparam int          IOR_CYCLES  = 1;
   localparam int          CALL_CYCLES = 2;

   // Four phases of one instruction cycle
   typedef enum logic [1:0] {
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } phase_t;

   // Operation held for the running cycle
   typedef enum logic [1:0] {
      OP_NOP,
      OP_IOR,
      OP_CALL
   } op_t;

endpackage

// file: src/or_call_exec.sv
// Decode and execute unit for OR-into-file and long subroutine call
`timescale 1ns/1ps

module or_call_exec (
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        clkEn,
   input  wire logic [15:0] instrWord,
   input  wire logic [7:0]  fileRdData,
   input  wire logic [7:0]  pcHighLatch,
   output logic [7:0]       workingRegister,
   output logic             zeroFlag,
   output logic [15:0]      pc,
   output logic [7:0]       fileAddr,
   output logic             fileRdEn,
   output logic             fileWrEn,
   output logic [7:0]       fileWrData,
   output logic             stackPush,
   output logic [15:0]      topOfStack,
   output logic             cycleStart
);

   // Phase sequencer and decoded operation
   or_call_pkg::phase_t phase;
   or_call_pkg::phase_t next_phase;
   or_call_pkg::op_t    op;
   or_call_pkg::op_t    next_op;
   logic                dest;
   logic                next_dest;
   logic [7:0]          lit;
   logic [7:0]          next_lit;
   logic                flushNext;
   logic                next_flushNext;

   // Datapath registers
   logic [7:0]          operand;
   logic [7:0]          next_operand;
   logic [7:0]          result;
   logic [7:0]          next_result;

   // Next values of the outputs
   logic [7:0]          next_workingRegister;
   logic                next_zeroFlag;
   logic [15:0]         next_pc;
   logic [7:0]          next_fileAddr;
   logic                next_fileRdEn;
   logic                next_fileWrEn;
   logic [7:0]          next_fileWrData;
   logic                next_stackPush;
   logic [15:0]         next_topOfStack;
   logic                next_cycleStart;

   // Opcode matches on the fetched word
   logic                isIor;
   logic                isCall;

   // Decode of the prefetched word
   assign isIor  = instrWord[15:or_call_pkg::IOR_OPC_LSB]
                   == or_call_pkg::IOR_OPC;
   assign isCall = instrWord[15:or_call_pkg::CALL_OPC_LSB]
                   == or_call_pkg::CALL_OPC;

   // Next-state logic; one phase step per enabled clock
   always_comb begin
      next_phase           = phase;
      next_op              = op;
      next_dest            = dest;
      next_lit             = lit;
      next_flushNext       = flushNext;
      next_operand         = operand;
      next_result          = result;
      next_workingRegister = workingRegister;
      next_zeroFlag        = zeroFlag;
      next_pc              = pc;
      next_fileAddr        = fileAddr;
      next_fileRdEn        = 1'b0;
      next_fileWrEn        = 1'b0;
      next_fileWrData      = fileWrData;
      next_stackPush       = 1'b0;
      next_topOfStack      = topOfStack;
      next_cycleStart      = 1'b0;

      unique case (phase)
         // Q1: decode; a flushed word becomes a no-operation
         or_call_pkg::PH_Q1: begin
            next_phase     = or_call_pkg::PH_Q2;
            next_flushNext = 1'b0;
            next_dest      = instrWord[or_call_pkg::IOR_DST_BIT];
            next_lit       = instrWord[7:0];
            if (flushNext) begin
               next_op = or_call_pkg::OP_NOP;
            end else if (isIor) begin
               next_op       = or_call_pkg::OP_IOR;
               next_fileAddr = instrWord[7:0];
               next_fileRdEn = 1'b1;
            end else if (isCall) begin
               next_op = or_call_pkg::OP_CALL;
            end else begin
               next_op = or_call_pkg::OP_NOP;
            end
         end

         // Q2: the file byte is returned during this phase
         or_call_pkg::PH_Q2: begin
            next_phase = or_call_pkg::PH_Q3;
            if (op == or_call_pkg::OP_IOR) begin
               next_operand = fileRdData;
            end
         end

         // Q3: execute the OR
         or_call_pkg::PH_Q3: begin
            next_phase = or_call_pkg::PH_Q4;
            if (op == or_call_pkg::OP_IOR) begin
               next_result = workingRegister | operand;
            end
         end

         // Q4: write the destination or redirect the counter
         or_call_pkg::PH_Q4: begin
            next_phase      = or_call_pkg::PH_Q1;
            next_cycleStart = 1'b1;
            next_pc         = pc + or_call_pkg::PC_STEP;
            if (op == or_call_pkg::OP_IOR) begin
               if (dest == or_call_pkg::DST_FILE) begin
                  next_fileWrEn   = 1'b1;
                  next_fileWrData = result;
               end else begin
                  next_workingRegister = result;
               end
               // Only the zero flag moves; other status lives elsewhere
               next_zeroFlag = (result == 8'h00);
            end else if (op == or_call_pkg::OP_CALL) begin
               // Return address is taken from the old counter and pushed on the same edge as the jump
               next_stackPush  = 1'b1;
               next_topOfStack = pc + or_call_pkg::PC_STEP;
               next_pc         = {pcHighLatch, lit};
               // The word already fetched is the wrong path
               next_flushNext  = 1'b1;
               // No flag is assigned here, so status holds
            end
         end
      endcase
   end

   // State registers; clkEn low freezes every flop
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         phase           <= or_call_pkg::PH_Q1;
         op              <= or_call_pkg::OP_NOP;
         dest            <= or_call_pkg::DST_WORK;
         lit             <= 8'h00;
         flushNext       <= 1'b0;
         operand         <= 8'h00;
         result          <= 8'h00;
         workingRegister <= or_call_pkg::WORK_RST;
         zeroFlag        <= or_call_pkg::ZF_RST;
         pc              <= or_call_pkg::PC_RST;
         fileAddr        <= 8'h00;
         fileRdEn        <= 1'b0;
         fileWrEn        <= 1'b0;
         fileWrData      <= 8'h00;
         stackPush       <= 1'b0;
         topOfStack      <= or_call_pkg::PC_RST;
         cycleStart      <= 1'b0;
      end else if (clkEn) begin
         phase           <= next_phase;
         op              <= next_op;
         dest            <= next_dest;
         lit             <= next_lit;
         flushNext       <= next_flushNext;
         operand         <= next_operand;
         result          <= next_result;
         workingRegister <= next_workingRegister;
         zeroFlag        <= next_zeroFlag;
         pc              <= next_pc;
         fileAddr        <= next_fileAddr;
         fileRdEn        <= next_fileRdEn;
         fileWrEn        <= next_fileWrEn;
         fileWrData      <= next_fileWrData;
         stackPush       <= next_stackPush;
         topOfStack      <= next_topOfStack;
         cycleStart      <= next_cycleStart;
      end
   end

   // Checks on the datapath and sequencing
   default clocking cbSys @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   // Enabled edges in phases Q1, Q3 and Q4
   sequence s_q1Ior;
      clkEn && phase == or_call_pkg::PH_Q1 && !flushNext && isIor;
   endsequence

   sequence s_q3Ior;
      clkEn && phase == or_call_pkg::PH_Q3 && op == or_call_pkg::OP_IOR;
   endsequence

   sequence s_q4Ior;
      clkEn && phase == or_call_pkg::PH_Q4 && op == or_call_pkg::OP_IOR;
   endsequence

   sequence s_q4Call;
      clkEn && phase == or_call_pkg::PH_Q4 && op == or_call_pkg::OP_CALL;
   endsequence

   sequence s_q1Flush;
      clkEn && phase == or_call_pkg::PH_Q1 && flushNext;
   endsequence

   property p_iorDecode;
      s_q1Ior |=> op == or_call_pkg::OP_IOR && fileRdEn
                  && fileAddr == $past(instrWord[7:0]);
   endproperty
   a_iorDecode: assert property (p_iorDecode)
      else $error("OR opcode not decoded or read not issued");

   property p_iorOr;
      s_q3Ior |=> result == ($past(workingRegister) | $past(operand));
   endproperty
   a_iorOr: assert property (p_iorOr)
      else $error("OR result wrong");

   property p_destWork;
      s_q4Ior ##0 (dest == or_call_pkg::DST_WORK)
         |=> workingRegister == $past(result) && !fileWrEn;
   endproperty
   a_destWork: assert property (p_destWork)
      else $error("Working register destination not written");

   property p_destFile;
      s_q4Ior ##0 (dest == or_call_pkg::DST_FILE)
         |=> fileWrEn && fileWrData == $past(result)
             && $stable(workingRegister);
   endproperty
   a_destFile: assert property (p_destFile)
      else $error("File destination not written");

   property p_zeroSet;
      s_q4Ior |=> zeroFlag == ($past(result) == 8'h00);
   endproperty
   a_zeroSet: assert property (p_zeroSet)
      else $error("Zero flag not following the OR result");

   // Three more enabled edges after decode carry the OR to write-back
   sequence s_iorSpan;
      s_q1Ior ##1 clkEn [*3];
   endsequence

   property p_iorFlow;
      s_iorSpan |=> phase == or_call_pkg::PH_Q1 && cycleStart
                    && !fileRdEn;
   endproperty
   a_iorFlow: assert property (p_iorFlow)
      else $error("OR did not finish within one instruction cycle");

   property p_callJump;
      s_q4Call |=> stackPush && pc == {$past(pcHighLatch), $past(lit)}
                   && topOfStack == $past(pc) + or_call_pkg::PC_STEP
                   && flushNext;
   endproperty
   a_callJump: assert property (p_callJump)
      else $error("Call push or target wrong");

   property p_callFlags;
      s_q4Call |=> $stable(zeroFlag) && $stable(workingRegister);
   endproperty
   a_callFlags: assert property (p_callFlags)
      else $error("Call changed a flag");

   // The flush mark set by a call turns the next decoded word into a no-operation and clears
   property p_callFlush;
      s_q1Flush |=> op == or_call_pkg::OP_NOP && !fileRdEn && !flushNext;
   endproperty
   a_callFlush: assert property (p_callFlush)
      else $error("Word after a call was not forced to no-operation");

   property p_noFileOnCall;
      s_q4Call |=> !fileWrEn;
   endproperty
   a_noFileOnCall: assert property (p_noFileOnCall)
      else $error("Call wrote data memory");

   property p_phaseStep;
      clkEn && phase == or_call_pkg::PH_Q4 |=> phase == or_call_pkg::PH_Q1
                                               && cycleStart;
   endproperty
   a_phaseStep: assert property (p_phaseStep)
      else $error("Phase did not wrap after Q4");

endmodule

// file: tb/tb_top.sv
// Self-checking bench for the OR-file and long-call unit
`timescale 1ns/1ps

`define CHK(a, b) chk(16'(a), 16'(b))

module tb_top;
   logic        clk_sys     = 1'h0;
   logic        nrst        = 1'h0;
   logic        clkEn       = 1'h1;
   logic [15:0] instrWord   = 16'h0000;
   logic [7:0]  fileRdData  = 8'h00;
   logic [7:0]  pcHighLatch = 8'h00;
   logic [7:0]  workingRegister;
   logic        zeroFlag;
   logic [15:0] pc;
   logic [7:0]  fileAddr;
   logic        fileRdEn;
   logic        fileWrEn;
   logic [7:0]  fileWrData;
   logic        stackPush;
   logic [15:0] topOfStack;
   logic        cycleStart;
   int          num_errors  = 0;
   int          n_checks    = 0;
   logic [15:0] expPc       = 16'h0000;
   logic        sawRd;

   or_call_exec u_dut (
      .clk_sys         (clk_sys),
      .nrst            (nrst),
      .clkEn           (clkEn),
      .instrWord       (instrWord),
      .fileRdData      (fileRdData),
      .pcHighLatch     (pcHighLatch),
      .workingRegister (workingRegister),
      .zeroFlag        (zeroFlag),
      .pc              (pc),
      .fileAddr        (fileAddr),
      .fileRdEn        (fileRdEn),
      .fileWrEn        (fileWrEn),
      .fileWrData      (fileWrData),
      .stackPush       (stackPush),
      .topOfStack      (topOfStack),
      .cycleStart      (cycleStart)
   );

   // 100 MHz core clock
   always #5 clk_sys = ~clk_sys;

   // Compare and count; four-state equality so an unknown only matches an unknown
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One instruction cycle; optional stall after decode checks the freeze
   task automatic exec(input logic [15:0] w, input logic [7:0] rd,
                       input int stall);
      instrWord = w;
      fileRdData = rd;
      @(posedge clk_sys);
      #1;
      sawRd = fileRdEn;
      if (stall > 0) begin
         clkEn = 1'h0;
         repeat (stall) @(posedge clk_sys);
         #1;
         `CHK(fileRdEn, sawRd);
         clkEn = 1'h1;
      end
      repeat (3) @(posedge clk_sys);
      #1;
      expPc = expPc + 16'h0001;
   endtask

   // Zero result sets the flag, destination is the working register
   task automatic test_or_zero;
      exec({7'h04, 1'h0, 8'h20}, 8'h00, 0);
      `CHK(sawRd, 1'h1);
      `CHK(fileAddr, 8'h20);
      `CHK(workingRegister, 8'h00);
      `CHK(zeroFlag, 1'h1);
      `CHK(fileWrEn, 1'h0);
      `CHK(cycleStart, 1'h1);
      `CHK(pc, expPc);
      $display("test_or_zero done");
   endtask

   // Call across the carry boundary, then the flushed word must do nothing
   task automatic test_call;
      logic [15:0] oldPc;
      oldPc = expPc;
      pcHighLatch = 8'hfe;
      exec(16'hb7ff, 8'h00, 0);
      `CHK(sawRd, 1'h0);
      `CHK(pc, 16'hfeff);
      `CHK(topOfStack, oldPc + 16'h0001);
      `CHK(stackPush, 1'h1);
      `CHK(zeroFlag, 1'h1);
      `CHK(workingRegister, 8'h00);
      // Latch changes after the call edge must not matter any more
      pcHighLatch = 8'h12;
      expPc = 16'hfeff; // Exec adds one: flushed word ends at target plus one
      exec({7'h04, 1'h0, 8'h44}, 8'hff, 0);
      `CHK(sawRd, 1'h0);
      `CHK(workingRegister, 8'h00);
      `CHK(zeroFlag, 1'h1);
      `CHK(stackPush, 1'h0);
      `CHK(pc, expPc);
      $display("test_call done");
   endtask

   // Both destinations, top file address, a frozen phase mid-instruction
   task automatic test_or_dest;
      exec({7'h04, 1'h0, 8'hff}, 8'h13, 2);
      `CHK(sawRd, 1'h1);
      `CHK(fileAddr, 8'hff);
      `CHK(workingRegister, 8'h13);
      `CHK(zeroFlag, 1'h0);
      `CHK(fileWrEn, 1'h0);
      exec({7'h04, 1'h1, 8'h5a}, 8'h91, 0);
      `CHK(fileWrEn, 1'h1);
      `CHK(fileWrData, 8'h93);
      `CHK(fileAddr, 8'h5a);
      `CHK(workingRegister, 8'h13);
      `CHK(pc, expPc);
      $display("test_or_dest done");
   endtask

   // Near-miss opcodes run as no-operations
   task automatic test_unknown;
      exec(16'h0a33, 8'h00, 0);
      `CHK(sawRd, 1'h0);
      `CHK(fileWrEn, 1'h0);
      `CHK(workingRegister, 8'h13);
      exec(16'hb633, 8'h00, 0);
      `CHK(stackPush, 1'h0);
      `CHK(pc, expPc);
      $display("test_unknown done");
   endtask

   // Single exit point for both normal end and watchdog
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Main sequence; zero flag is set first so the call can prove it holds
   initial begin
      repeat (2) @(posedge clk_sys);
      #1;
      nrst = 1'h1;
      test_or_zero;
      test_call;
      test_or_dest;
      test_unknown;
      final_report;
   end

   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #20000;
      num_errors++;
      final_report;
   end
endmodule
